// [core/psdc_pkg.sv]
// Purpose: Shared constants and types of the synthesizer core and its host
// Assumes: 20 MHz system clock on both ends
// Notes: Field positions are bit indices inside the 24-bit serial word
package psdc_pkg;
  localparam int WORD_W = 24;
  localparam int CLK_PERIOD_NS = 50;
  // Destination select in word bits 1:0
  localparam logic [1:0] ROUTE_REF = 2'h0;
  localparam logic [1:0] ROUTE_FB = 2'h1;
  localparam logic [1:0] ROUTE_FUNC = 2'h2;
  localparam logic [1:0] ROUTE_INIT = 2'h3;
  localparam logic [23:0] WORD_RESET = 24'h00_0000;
  // Reference divider word
  localparam int REF_RATIO_LSB = 2;
  localparam int REF_RATIO_W = 14;
  localparam int REF_DZ_LSB = 16;
  localparam int REF_TEST_LSB = 18;
  localparam int REF_LDP_BIT = 20;
  localparam int REF_NOISE_LSB = 21;
  // Feedback divider word
  localparam int FB_A_LSB = 2;
  localparam int FB_A_W = 6;
  localparam int FB_B_LSB = 8;
  localparam int FB_B_W = 13;
  localparam int FB_GAIN_BIT = 21;
  // Function word
  localparam int FN_MUX_LSB = 4;
  localparam int FN_PRE_LSB = 22;
  localparam logic [6:0] PRE_BASE = 7'h08;
  // Lock detect qualification
  localparam int LOCK_SET_NS = 15;
  localparam int LOCK_CLR_NS = 25;
  localparam logic [2:0] LOCK_NEED_LO = 3'h3;
  localparam logic [2:0] LOCK_NEED_HI = 3'h5;
  // Status output selection codes
  localparam logic [2:0] MUX_LOW = 3'h0;
  localparam logic [2:0] MUX_LOCK = 3'h1;
  localparam logic [2:0] MUX_FB = 3'h2;
  localparam logic [2:0] MUX_HIGH = 3'h3;
  localparam logic [2:0] MUX_REF = 3'h4;
  // Host serial timing
  localparam int SCLK_HALF_NS = 200;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  // Host register map, byte offsets
  localparam logic [7:0] ADDR_TXDATA = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h14;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_MUXRISE = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {PD_IDLE, PD_REF_LEAD, PD_FB_LEAD} psdc_pd_t;
  typedef enum logic [2:0] {TX_IDLE, TX_LOW, TX_HIGH, TX_STROBE} psdc_tx_t;

  function automatic logic rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  function automatic logic [31:0] strbMerge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction
endpackage

// [core/psdc_link_if.sv]
// Purpose: Three-wire load link plus status line between host and core
// Assumes: Both ends run from the same 20 MHz clock tree
// Notes: Link lines are still synchronised at the receiving end
`timescale 1ns/10ps
`default_nettype none
interface psdc_link_if;
  logic sclk;
  logic sdata;
  logic loadStrobe;
  logic muxOut;
  modport host (output sclk, output sdata, output loadStrobe,
                input muxOut);
  modport device (input sclk, input sdata, input loadStrobe,
                  output muxOut);
endinterface
`default_nettype wire

// [core/psdc_device.sv]
// Purpose: Digital core of the synthesizer: serial load, dividers, lock
// Assumes: Link and divider inputs are slow next to clk and are synchronised
// Notes: Phase error is resolved to one clk period only
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module psdc_device (
  // System
  input wire logic clk,
  input wire logic rst,
  // Link to host
  psdc_link_if.device link,
  // Divider inputs
  input wire logic reference_input,
  input wire logic rfIn,
  // Phase detector clocks and lock detect
  output logic refPulse,
  output logic fbPulse,
  output logic lockDetect,
  // Option settings
  output logic [1:0] deadzoneWidth,
  output logic [1:0] testMode,
  output logic [1:0] noiseOpt,
  output logic pumpGain,
  output logic [23:0] functionWord,
  output logic [23:0] initWord
);
  localparam int P_SCLK = 4;
  localparam int P_SDAT = 3;
  localparam int P_STRB = 2;
  localparam int P_REF = 1;
  localparam int P_RF = 0;

  logic [4:0] pinMeta_reg;
  logic [4:0] pinSync_reg;
  logic [4:0] pinPrev_reg;
  logic sclkRise;
  logic strobeRise;
  logic refRise;
  logic rfRise;

  // Two stages per pin; edges look only at the second stage onward
  always_ff @(posedge clk) begin
    if (rst) begin
      pinMeta_reg <= 5'h00;
      pinSync_reg <= 5'h00;
      pinPrev_reg <= 5'h00;
    end else begin
      pinMeta_reg <= {link.sclk, link.sdata, link.loadStrobe, reference_input, rfIn};
      pinSync_reg <= pinMeta_reg;
      pinPrev_reg <= pinSync_reg;
    end
  end

  assign sclkRise = psdc_pkg::rise(pinSync_reg[P_SCLK], pinPrev_reg[P_SCLK]);
  assign strobeRise = psdc_pkg::rise(pinSync_reg[P_STRB],
                                     pinPrev_reg[P_STRB]);
  assign refRise = psdc_pkg::rise(pinSync_reg[P_REF], pinPrev_reg[P_REF]);
  assign rfRise = psdc_pkg::rise(pinSync_reg[P_RF], pinPrev_reg[P_RF]);

  logic [23:0] shiftWord_reg;
  logic [23:0] refWord_reg;
  logic [23:0] fbWord_reg;
  logic [23:0] funcWord_reg;
  logic [23:0] initWord_reg;

  // Data line shares the clock line's delay, so it is stable here
  always_ff @(posedge clk) begin
    if (rst) begin
      shiftWord_reg <= psdc_pkg::WORD_RESET;
    end else if (sclkRise) begin
      shiftWord_reg <= {shiftWord_reg[22:0], pinSync_reg[P_SDAT]};
    end
  end

  // Shifting alone never disturbs the live settings
  always_ff @(posedge clk) begin
    if (rst) begin
      refWord_reg <= psdc_pkg::WORD_RESET;
      fbWord_reg <= psdc_pkg::WORD_RESET;
      funcWord_reg <= psdc_pkg::WORD_RESET;
      initWord_reg <= psdc_pkg::WORD_RESET;
    end else if (strobeRise) begin
      case (shiftWord_reg[1:0])
        psdc_pkg::ROUTE_REF: refWord_reg <= shiftWord_reg;
        psdc_pkg::ROUTE_FB: fbWord_reg <= shiftWord_reg;
        psdc_pkg::ROUTE_FUNC: funcWord_reg <= shiftWord_reg;
        psdc_pkg::ROUTE_INIT: initWord_reg <= shiftWord_reg;
        default: refWord_reg <= refWord_reg;
      endcase
    end
  end

  logic [13:0] refRatio;
  logic [5:0] aValue;
  logic [12:0] bValue;
  logic [1:0] preSel;
  logic [2:0] muxSel;
  logic lockPrecision;

  // Bit 23 of the reference word and 23:22 of the feedback word unused
  assign refRatio = refWord_reg[psdc_pkg::REF_RATIO_LSB +:
                                psdc_pkg::REF_RATIO_W];
  assign lockPrecision = refWord_reg[psdc_pkg::REF_LDP_BIT];
  assign aValue = fbWord_reg[psdc_pkg::FB_A_LSB +: psdc_pkg::FB_A_W];
  assign bValue = fbWord_reg[psdc_pkg::FB_B_LSB +: psdc_pkg::FB_B_W];
  assign preSel = funcWord_reg[psdc_pkg::FN_PRE_LSB +: 2];
  assign muxSel = funcWord_reg[psdc_pkg::FN_MUX_LSB +: 3];

  logic [13:0] refCnt_reg;
  logic refPulse_reg;

  // A ratio of zero behaves as one rather than stalling
  always_ff @(posedge clk) begin
    if (rst) begin
      refCnt_reg <= 14'h0000;
      refPulse_reg <= 1'h0;
    end else begin
      refPulse_reg <= 1'h0;
      if (refRise) begin
        if (refCnt_reg + 14'h0001 >= refRatio) begin
          refCnt_reg <= 14'h0000;
          refPulse_reg <= 1'h1;
        end else begin
          refCnt_reg <= refCnt_reg + 14'h0001;
        end
      end
    end
  end

  logic [6:0] preBase;
  logic [6:0] modulus;
  logic swallow;
  logic [6:0] preCnt_reg;
  logic [5:0] aCnt_reg;
  logic [12:0] bCnt_reg;
  logic fbPulse_reg;

  assign preBase = psdc_pkg::PRE_BASE << preSel;
  assign swallow = aCnt_reg < aValue;
  assign modulus = swallow ? preBase + 7'h01 : preBase;

  // Counts are only right while A does not exceed B
  always_ff @(posedge clk) begin
    if (rst) begin
      preCnt_reg <= 7'h00;
      aCnt_reg <= 6'h00;
      bCnt_reg <= 13'h0000;
      fbPulse_reg <= 1'h0;
    end else begin
      fbPulse_reg <= 1'h0;
      if (rfRise) begin
        if (preCnt_reg + 7'h01 >= modulus) begin
          preCnt_reg <= 7'h00;
          if (bCnt_reg + 13'h0001 >= bValue) begin
            bCnt_reg <= 13'h0000;
            aCnt_reg <= 6'h00;
            fbPulse_reg <= 1'h1;
          end else begin
            bCnt_reg <= bCnt_reg + 13'h0001;
            if (swallow) begin
              aCnt_reg <= aCnt_reg + 6'h01;
            end
          end
        end else begin
          preCnt_reg <= preCnt_reg + 7'h01;
        end
      end
    end
  end

  psdc_pkg::psdc_pd_t pdState_reg;
  logic [7:0] pdCnt_reg;
  logic [7:0] pdErr_reg;
  logic pdDone_reg;
  logic [7:0] pdCntInc;

  assign pdCntInc = (pdCnt_reg == 8'hFF) ? pdCnt_reg : pdCnt_reg + 8'h01;

  // A repeat edge of the leading input counts as a worst-case error
  always_ff @(posedge clk) begin
    if (rst) begin
      pdState_reg <= psdc_pkg::PD_IDLE;
      pdCnt_reg <= 8'h00;
      pdErr_reg <= 8'h00;
      pdDone_reg <= 1'h0;
    end else begin
      pdDone_reg <= 1'h0;
      case (pdState_reg)
        psdc_pkg::PD_IDLE: begin
          pdCnt_reg <= 8'h00;
          if (refPulse_reg && fbPulse_reg) begin
            pdErr_reg <= 8'h00;
            pdDone_reg <= 1'h1;
          end else if (refPulse_reg) begin
            pdState_reg <= psdc_pkg::PD_REF_LEAD;
          end else if (fbPulse_reg) begin
            pdState_reg <= psdc_pkg::PD_FB_LEAD;
          end
        end
        psdc_pkg::PD_REF_LEAD, psdc_pkg::PD_FB_LEAD: begin
          if ((pdState_reg == psdc_pkg::PD_REF_LEAD) ? fbPulse_reg
              : refPulse_reg) begin
            pdErr_reg <= pdCntInc;
            pdDone_reg <= 1'h1;
            pdState_reg <= psdc_pkg::PD_IDLE;
          end else if ((pdState_reg == psdc_pkg::PD_REF_LEAD) ? refPulse_reg
                       : fbPulse_reg) begin
            pdErr_reg <= 8'hFF;
            pdDone_reg <= 1'h1;
            pdCnt_reg <= 8'h00;
          end else begin
            pdCnt_reg <= pdCntInc;
          end
        end
        default: pdState_reg <= psdc_pkg::PD_IDLE;
      endcase
    end
  end

  logic [2:0] lockNeed;
  logic [2:0] goodCnt_reg;
  logic lock_reg;
  int errNs;

  assign lockNeed = lockPrecision ? psdc_pkg::LOCK_NEED_HI
                                  : psdc_pkg::LOCK_NEED_LO;
  assign errNs = int'(pdErr_reg) * psdc_pkg::CLK_PERIOD_NS;

  always_ff @(posedge clk) begin
    if (rst) begin
      goodCnt_reg <= 3'h0;
      lock_reg <= 1'h0;
    end else if (pdDone_reg) begin
      if (errNs < psdc_pkg::LOCK_SET_NS) begin
        if (goodCnt_reg + 3'h1 >= lockNeed) begin
          lock_reg <= 1'h1;
        end else begin
          goodCnt_reg <= goodCnt_reg + 3'h1;
        end
      end else begin
        goodCnt_reg <= 3'h0;
        if (errNs > psdc_pkg::LOCK_CLR_NS) begin
          lock_reg <= 1'h0;
        end
      end
    end
  end

  logic muxOut_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      muxOut_reg <= 1'h0;
    end else begin
      case (muxSel)
        psdc_pkg::MUX_LOW: muxOut_reg <= 1'h0;
        psdc_pkg::MUX_LOCK: muxOut_reg <= lock_reg;
        psdc_pkg::MUX_FB: muxOut_reg <= fbPulse_reg;
        psdc_pkg::MUX_HIGH: muxOut_reg <= 1'h1;
        psdc_pkg::MUX_REF: muxOut_reg <= refPulse_reg;
        default: muxOut_reg <= 1'h0;
      endcase
    end
  end

  assign link.muxOut = muxOut_reg;
  assign refPulse = refPulse_reg;
  assign fbPulse = fbPulse_reg;
  assign lockDetect = lock_reg;
  assign deadzoneWidth = refWord_reg[psdc_pkg::REF_DZ_LSB +: 2];
  assign testMode = refWord_reg[psdc_pkg::REF_TEST_LSB +: 2];
  assign noiseOpt = refWord_reg[psdc_pkg::REF_NOISE_LSB +: 2];
  assign pumpGain = fbWord_reg[psdc_pkg::FB_GAIN_BIT];
  assign functionWord = funcWord_reg;
  assign initWord = initWord_reg;
endmodule // psdc_device
`default_nettype wire

// [core/psdc_host.sv]
// Purpose: Host end: AXI4-Lite registers driving the three-wire load link
// Assumes: Software writes the word, then starts it through the control reg
// Notes: Words are sent raw; range checks of divider values are software's
`timescale 1ns/10ps
`default_nettype none
module psdc_host (
  // System
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Interrupt
  output logic irq,
  // Link to core
  psdc_link_if.host link
);
  logic awGot_reg;
  logic wGot_reg;
  logic [7:0] wAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic wrEn;
  logic wrKnown;

  assign awready = !awGot_reg && !bvalid_reg;
  assign wready = !wGot_reg && !bvalid_reg;
  assign arready = !rvalid_reg;
  assign wrEn = awGot_reg && wGot_reg && !bvalid_reg;
  assign wrKnown = wAddr_reg == psdc_pkg::ADDR_TXDATA
      || wAddr_reg == psdc_pkg::ADDR_CTRL
      || wAddr_reg == psdc_pkg::ADDR_IRQ_CLR
      || wAddr_reg == psdc_pkg::ADDR_IRQ_EN;

  always_ff @(posedge clk) begin
    if (rst) begin
      awGot_reg <= 1'h0;
      wGot_reg <= 1'h0;
      wAddr_reg <= 8'h00;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
      bvalid_reg <= 1'h0;
      bresp_reg <= psdc_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awGot_reg <= 1'h1;
        wAddr_reg <= {awaddr[7:2], 2'h0};
      end
      if (wvalid && wready) begin
        wGot_reg <= 1'h1;
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end
      if (wrEn) begin
        awGot_reg <= 1'h0;
        wGot_reg <= 1'h0;
        bvalid_reg <= 1'h1;
        bresp_reg <= wrKnown ? psdc_pkg::RESP_OKAY : psdc_pkg::RESP_SLVERR;
      end else if (bvalid_reg && bready) begin
        bvalid_reg <= 1'h0;
      end
    end
  end

  logic [23:0] txData_reg;
  logic [1:0] irqEn_reg;
  logic [1:0] irqStat_reg;
  logic [1:0] irqEvent;
  logic [1:0] irqClr;
  logic [31:0] txMerged;
  logic [31:0] enMerged;
  logic busy;
  logic muxMeta_reg;
  logic muxSync_reg;
  logic muxPrev_reg;
  logic txDone_reg;

  assign txMerged = psdc_pkg::strbMerge({8'h00, txData_reg}, wData_reg,
                                        wStrb_reg);
  assign enMerged = psdc_pkg::strbMerge({30'h0000_0000, irqEn_reg},
                                        wData_reg, wStrb_reg);
  assign irqClr = (wrEn && wAddr_reg == psdc_pkg::ADDR_IRQ_CLR)
                  ? wData_reg[1:0] : 2'h0;
  assign irqEvent = {psdc_pkg::rise(muxSync_reg, muxPrev_reg), txDone_reg};

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      txData_reg <= 24'h00_0000;
      irqEn_reg <= 2'h0;
      irqStat_reg <= 2'h0;
      muxMeta_reg <= 1'h0;
      muxSync_reg <= 1'h0;
      muxPrev_reg <= 1'h0;
    end else begin
      muxMeta_reg <= link.muxOut;
      muxSync_reg <= muxMeta_reg;
      muxPrev_reg <= muxSync_reg;
      irqStat_reg <= (irqStat_reg & ~irqClr) | irqEvent;
      if (wrEn && wAddr_reg == psdc_pkg::ADDR_TXDATA) begin
        txData_reg <= txMerged[23:0];
      end
      if (wrEn && wAddr_reg == psdc_pkg::ADDR_IRQ_EN) begin
        irqEn_reg <= enMerged[1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rvalid_reg <= 1'h0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= psdc_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_reg <= 1'h1;
      rresp_reg <= psdc_pkg::RESP_OKAY;
      case ({araddr[7:2], 2'h0})
        psdc_pkg::ADDR_TXDATA: rdata_reg <= {8'h00, txData_reg};
        psdc_pkg::ADDR_STATUS: rdata_reg <= {30'h0000_0000, muxSync_reg,
                                             busy};
        psdc_pkg::ADDR_IRQ_STAT: rdata_reg <= {30'h0000_0000, irqStat_reg};
        psdc_pkg::ADDR_IRQ_EN: rdata_reg <= {30'h0000_0000, irqEn_reg};
        psdc_pkg::ADDR_CTRL, psdc_pkg::ADDR_IRQ_CLR:
          rdata_reg <= 32'h0000_0000;
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= psdc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'h0;
    end
  end

  psdc_pkg::psdc_tx_t txState_reg;
  logic [23:0] txShift_reg;
  logic [4:0] bitCnt_reg;
  logic [7:0] divCnt_reg;
  logic halfTick;
  logic sclk_reg;
  logic strobe_reg;

  assign busy = txState_reg != psdc_pkg::TX_IDLE;
  assign halfTick = divCnt_reg == 8'(psdc_pkg::SCLK_HALF_CYC - 1);

  always_ff @(posedge clk) begin
    if (rst || !busy || halfTick) begin
      divCnt_reg <= 8'h00;
    end else begin
      divCnt_reg <= divCnt_reg + 8'h01;
    end
  end

  // Data changes only with the falling clock or at frame start while the clock is low, so the core samples it stable
  always_ff @(posedge clk) begin
    if (rst) begin
      txState_reg <= psdc_pkg::TX_IDLE;
      txShift_reg <= 24'h00_0000;
      bitCnt_reg <= 5'h00;
      sclk_reg <= 1'h0;
      strobe_reg <= 1'h0;
      txDone_reg <= 1'h0;
    end else begin
      txDone_reg <= 1'h0;
      case (txState_reg)
        psdc_pkg::TX_IDLE: begin
          if (wrEn && wAddr_reg == psdc_pkg::ADDR_CTRL && wStrb_reg[0]
              && wData_reg[0]) begin
            txShift_reg <= txData_reg;
            bitCnt_reg <= 5'h17;
            txState_reg <= psdc_pkg::TX_LOW;
          end
        end
        psdc_pkg::TX_LOW: if (halfTick) begin
          sclk_reg <= 1'h1;
          txState_reg <= psdc_pkg::TX_HIGH;
        end
        psdc_pkg::TX_HIGH: if (halfTick) begin
          sclk_reg <= 1'h0;
          if (bitCnt_reg == 5'h00) begin
            strobe_reg <= 1'h1;
            txState_reg <= psdc_pkg::TX_STROBE;
          end else begin
            bitCnt_reg <= bitCnt_reg - 5'h01;
            txShift_reg <= {txShift_reg[22:0], 1'h0};
            txState_reg <= psdc_pkg::TX_LOW;
          end
        end
        psdc_pkg::TX_STROBE: if (halfTick) begin
          strobe_reg <= 1'h0;
          txDone_reg <= 1'h1;
          txState_reg <= psdc_pkg::TX_IDLE;
        end
        default: txState_reg <= psdc_pkg::TX_IDLE;
      endcase
    end
  end

  assign link.sclk = sclk_reg;
  assign link.sdata = txShift_reg[23];
  assign link.loadStrobe = strobe_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign irq = |(irqStat_reg & irqEn_reg);
endmodule // psdc_host
`default_nettype wire

// [tb/psdc_link_properties.sv]
// Purpose: Wire checks of the load link between host and core
// Assumes: One clock domain, link lines driven from registers
// Notes: Widths follow the 4-clk serial half period
`timescale 1ns/10ps
`default_nettype none
module psdc_link_properties (
  // System
  input wire logic clk,
  input wire logic rst,
  // Link
  input wire logic sclk,
  input wire logic sdata,
  input wire logic loadStrobe,
  input wire logic muxOut
);
  logic [4:0] bits_reg;
  logic sclkOld_reg;
  logic loaded_reg;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  always_ff @(posedge clk) begin
    sclkOld_reg <= sclk;
  end
  // Cleared while the strobe is up, so it counts one frame only
  always_ff @(posedge clk) begin
    if (rst || loadStrobe) begin
      bits_reg <= 5'h00;
    end else if (sclk && !sclkOld_reg) begin
      bits_reg <= bits_reg + 5'h01;
    end
  end
  always_ff @(posedge clk) begin
    loaded_reg <= !rst && (loaded_reg || loadStrobe);
  end
  a_sclk_high_width: assert property (
      $rose(sclk) |=> sclk [*3] ##1 !sclk)
    else $error("serial clock high time wrong");
  a_sclk_low_width: assert property (
      $fell(sclk) && !loadStrobe |=> !sclk [*3] ##1 sclk)
    else $error("serial clock low time wrong");
  a_data_steady: assert property (
      $rose(sclk) |-> $stable(sdata) ##1 $stable(sdata) [*3])
    else $error("serial data moved while clock high");
  a_word_length: assert property (
      $rose(loadStrobe) |-> bits_reg == 5'h18)
    else $error("frame is not 24 bits");
  a_strobe_after_word: assert property (
      $rose(loadStrobe) |-> $fell(sclk))
    else $error("strobe not at last clock fall");
  a_strobe_width: assert property (
      $rose(loadStrobe) |-> loadStrobe [*4] ##1 !loadStrobe)
    else $error("strobe width wrong");
  a_clock_quiet_load: assert property (loadStrobe |-> !sclk)
    else $error("serial clock high during strobe");
  a_status_before_load: assert property (
      !loaded_reg |-> !muxOut)
    else $error("status line high before any load");
endmodule // psdc_link_properties
`default_nettype wire

// [tb/psdc_tb.sv]
// Purpose: End-to-end bench of host registers, load link and core
// Assumes: 20 MHz clock shared by both ends
// Notes: Divider and lock checks use slow pulse trains on the inputs
`timescale 1ns/10ps
`default_nettype none
module psdc_tb;
  typedef struct packed {
    logic [23:0] word;
    logic [6:0] expOpt;
    logic expMux;
  } psdc_row_t;
  localparam int LIMIT = 20000;
  // Option outputs packed as noise, test, dead zone, gain
  localparam psdc_row_t ROWS [8] = '{
    '{24'hC7_0004, 7'h4E, 1'h0}, '{24'hE0_0405, 7'h4F, 1'h0},
    '{24'h00_0022, 7'h4F, 1'h0}, '{24'h00_0052, 7'h4F, 1'h0},
    '{24'h00_0042, 7'h4F, 1'h0}, '{24'h00_0012, 7'h4F, 1'h0},
    '{24'h00_0032, 7'h4F, 1'h1}, '{24'hAB_CDEF, 7'h4F, 1'h1}};
  logic clk, rst, reference_input, rfIn, irq, refPulse, fbPulse, lockDetect, pumpGain;
  logic awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, resp, deadzoneWidth, testMode, noiseOpt;
  logic [23:0] functionWord, initWord, expFn, expInit, capShift, capWord;
  logic sclkOld = 1'h0;
  logic strbOld = 1'h0;
  int n_fail, checks_done, cycles, refCnt, fbCnt, c0;
  psdc_link_if link();
  psdc_host i_psdc_host (.clk(clk), .rst(rst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(1'h1), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'h1),
    .irq(irq), .link(link));
  psdc_device i_psdc_device (.clk(clk), .rst(rst), .link(link),
    .reference_input(reference_input), .rfIn(rfIn), .refPulse(refPulse), .fbPulse(fbPulse),
    .lockDetect(lockDetect), .deadzoneWidth(deadzoneWidth),
    .testMode(testMode), .noiseOpt(noiseOpt), .pumpGain(pumpGain),
    .functionWord(functionWord), .initWord(initWord));
  psdc_link_properties i_psdc_link_properties (.clk(clk), .rst(rst),
    .sclk(link.sclk), .sdata(link.sdata), .loadStrobe(link.loadStrobe),
    .muxOut(link.muxOut));
  task automatic report_and_stop();
    if (n_fail == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (!ok) begin
      n_fail++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  // Ready is looked at before the edge, so comb readys cannot race
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v);
    logic aw, w, b;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    b = 1'h0;
    while (!b) begin
      @(negedge clk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      resp = bresp;
      @(posedge clk);
      if (aw) awvalid <= 1'h0;
      if (w) wvalid <= 1'h0;
    end
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] v);
    logic ar, r;
    araddr <= a;
    arvalid <= 1'h1;
    r = 1'h0;
    while (!r) begin
      @(negedge clk);
      ar = arvalid && arready;
      r = rvalid;
      v = rdata;
      resp = rresp;
      @(posedge clk);
      if (ar) arvalid <= 1'h0;
    end
  endtask
  task automatic send(input logic [23:0] w);
    axi_write(psdc_pkg::ADDR_TXDATA, {8'h00, w});
    axi_write(psdc_pkg::ADDR_CTRL, 32'h0000_0001);
    check(resp === psdc_pkg::RESP_OKAY, "write response");
    axi_read(psdc_pkg::ADDR_STATUS, d);
    check(d[0] === 1'h1 && resp === psdc_pkg::RESP_OKAY, "not busy");
    while (irq !== 1'h1) @(posedge clk);
    repeat (3) @(posedge clk);
    check(capWord === w, "bits on the wire");
    axi_write(psdc_pkg::ADDR_IRQ_CLR, 32'h0000_0001);
    check(irq === 1'h0, "irq not cleared");
  endtask
  task automatic drive(input int n, input logic useRf, input logic useRef);
    repeat (n) begin
      rfIn <= useRf;
      reference_input <= useRef;
      repeat (2) @(posedge clk);
      rfIn <= 1'h0;
      reference_input <= 1'h0;
      repeat (2) @(posedge clk);
    end
    repeat (8) @(posedge clk);
  endtask
  // Coincident reference and feedback pulses with ratio 1 and N of 33
  task automatic good_cycles(input int n);
    repeat (n) begin
      drive(32, 1'h1, 1'h0);
      drive(1, 1'h1, 1'h1);
    end
  endtask
  always @(posedge clk) begin
    sclkOld <= link.sclk;
    strbOld <= link.loadStrobe;
    if (link.sclk && !sclkOld) capShift <= {capShift[22:0], link.sdata};
    if (link.loadStrobe && !strbOld) capWord <= capShift;
    if (refPulse) refCnt <= refCnt + 1;
    if (fbPulse) fbCnt <= fbCnt + 1;
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_fail++;
      $display("MISMATCH %0t timeout", $time);
      report_and_stop();
    end
  end
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  initial begin
    rst = 1'h1;
    {reference_input, rfIn, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    {expFn, expInit} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    axi_read(psdc_pkg::ADDR_IRQ_EN, d);
    check(d === 32'h0000_0000, "irq enable reset");
    axi_write(psdc_pkg::ADDR_IRQ_EN, 32'h0000_0001);
    for (int i = 0; i < 8; i++) begin
      send(ROWS[i].word);
      if (ROWS[i].word[1:0] === psdc_pkg::ROUTE_FUNC) expFn = ROWS[i].word;
      if (ROWS[i].word[1:0] === psdc_pkg::ROUTE_INIT) expInit = ROWS[i].word;
      check(ROWS[i].expOpt === {noiseOpt, testMode,
            deadzoneWidth, pumpGain}, "options");
      check({functionWord, initWord} === {expFn, expInit},
            "latches");
      check(link.muxOut === ROWS[i].expMux, "status line");
    end
    axi_read(psdc_pkg::ADDR_STATUS, d);
    check(d === 32'h0000_0002, "status word");
    // Status rise is latched but masked; unmapped places answer an error
    axi_read(psdc_pkg::ADDR_IRQ_STAT, d);
    check(d === 32'h0000_0002 && irq === 1'h0, "masked status event");
    axi_write(psdc_pkg::ADDR_IRQ_CLR, 32'h0000_0002);
    axi_read(psdc_pkg::ADDR_IRQ_STAT, d);
    check(d === 32'h0000_0000, "status clear");
    axi_read(8'h18, d);
    check(d === 32'h0000_0000 && resp === psdc_pkg::RESP_SLVERR, "bad read");
    axi_write(8'h1C, 32'h0000_0001);
    check(resp === psdc_pkg::RESP_SLVERR, "bad write");
    good_cycles(2);
    check(lockDetect === 1'h0, "lock too early");
    good_cycles(1);
    check(lockDetect === 1'h1, "no lock after three");
    drive(33, 1'h1, 1'h0);
    drive(1, 1'h0, 1'h1);
    check(lockDetect === 1'h0, "lock kept on big error");
    send(24'hD7_0004);
    good_cycles(4);
    check(lockDetect === 1'h0, "precise lock too early");
    good_cycles(1);
    check(lockDetect === 1'h1, "no lock after five");
    send(24'hC7_0014);
    c0 = refCnt;
    drive(4, 1'h0, 1'h1);
    check(refCnt == c0, "early reference pulse");
    drive(1, 1'h0, 1'h1);
    check(refCnt == c0 + 1, "reference ratio");
    for (int c = 0; c < 4; c++) begin
      send({c[1:0], 22'h00_0032});
      c0 = fbCnt;
      drive(32 << c, 1'h1, 1'h0);
      check(fbCnt == c0, "early feedback pulse");
      drive(1, 1'h1, 1'h0);
      check(fbCnt == c0 + 1, "feedback ratio");
    end
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    check({functionWord, initWord, lockDetect, link.muxOut} === '0, "reset");
    axi_read(psdc_pkg::ADDR_IRQ_EN, d);
    check(d === 32'h0000_0000, "irq enable after reset");
    report_and_stop();
  end
endmodule // psdc_tb
`default_nettype wire
